// file: hdl/alert_compare.sv
module alert_compare (
	input  monitor_pkg::alert_sel_t sel,
	input  logic [15:0]             limit,
	input  monitor_pkg::meas_t      sample,
	input  logic                    shunt_done,
	input  logic                    bus_done,
	output logic                    cmp_valid,
	output logic                    violate
);
	// Highest enabled function decides; one compare per conversion
	always_comb
	begin
		cmp_valid = 1'b0;
		violate   = 1'b0;
		if (sel.shunt_over_limit)
		begin
			cmp_valid = shunt_done;
			violate   = sample.shunt > $signed(limit);
		end
		else if (sel.shunt_under_limit)
		begin
			cmp_valid = shunt_done;
			violate   = sample.shunt < $signed(limit);
		end
		else if (sel.bus_over_limit)
		begin
			cmp_valid = bus_done;
			violate   = sample.bus > limit;
		end
		else if (sel.bus_under_limit)
		begin
			cmp_valid = bus_done;
			violate   = sample.bus < limit;
		end
		else if (sel.power_over_limit)
		begin
			cmp_valid = bus_done;
			violate   = sample.power > limit;
		end
	end
endmodule

// file: hdl/conv_sequencer.sv
`include "monitor_consts.svh"
module conv_sequencer #(
	parameter int unsigned CONV_CYC [8] = `CONV_CYC_DEFAULT
) (
	input  logic                   clk,
	input  logic                   reset,
	input  logic                   restart,
	input  monitor_pkg::conv_cfg_t cfg,
	input  monitor_pkg::meas_t     adc,
	output monitor_pkg::meas_t     sample,
	output logic                   shunt_done,
	output logic                   bus_done,
	output logic                   update_done,
	output monitor_pkg::meas_t     result
);
	localparam int TW = 20;
	localparam int AW = 26;

	monitor_pkg::seq_state_t state_q;
	monitor_pkg::seq_state_t state_d;
	logic [TW-1:0]           timer_q;
	logic [9:0]              count_q;
	logic signed [AW-1:0]    acc_s_q;
	logic signed [AW-1:0]    acc_c_q;
	logic [AW-1:0]           acc_b_q;
	logic [AW-1:0]           acc_p_q;
	logic [3:0]              shift;
	logic                    last_sample;
	logic                    end_shunt;
	logic                    end_bus;

	function automatic monitor_pkg::seq_state_t first_conv(
		input logic [2:0] mode);
		if (mode[0])
			first_conv = monitor_pkg::ST_SHUNT;
		else if (mode[1])
			first_conv = monitor_pkg::ST_BUS;
		else
			first_conv = monitor_pkg::ST_IDLE;
	endfunction

	function automatic logic [TW-1:0] load_val(input logic [2:0] ct);
		load_val = TW'(CONV_CYC[ct] - 1);
	endfunction

	// Averaging count 1,4,16,64,128,256,512,1024 as shift
	always_comb
	begin
		unique case (cfg.avg)
			3'h0: shift = 4'h0;
			3'h1: shift = 4'h2;
			3'h2: shift = 4'h4;
			3'h3: shift = 4'h6;
			3'h4: shift = 4'h7;
			3'h5: shift = 4'h8;
			3'h6: shift = 4'h9;
			3'h7: shift = 4'ha;
		endcase
	end

	assign last_sample = count_q == 10'((11'h1 << shift) - 11'h1);
	assign end_shunt = state_q == monitor_pkg::ST_SHUNT && timer_q == '0
		&& !restart;
	assign end_bus = state_q == monitor_pkg::ST_BUS && timer_q == '0
		&& !restart;

	// Shunt then bus, then wrap; restart re-enters from the top
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			monitor_pkg::ST_IDLE: state_d = state_q;
			monitor_pkg::ST_SHUNT:
				if (timer_q == '0)
					state_d = cfg.mode[1] ? monitor_pkg::ST_BUS
						: monitor_pkg::ST_WRAP;
			monitor_pkg::ST_BUS:
				if (timer_q == '0)
					state_d = monitor_pkg::ST_WRAP;
			monitor_pkg::ST_WRAP:
				if (last_sample && !cfg.mode[2])
					state_d = monitor_pkg::ST_IDLE;
				else
					state_d = first_conv(cfg.mode);
		endcase
		if (restart)
			state_d = first_conv(cfg.mode);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			state_q <= monitor_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	// Conversion timer, loaded per phase from its own field
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			timer_q <= '0;
		else if (state_q != state_d || restart)
			timer_q <= (state_d == monitor_pkg::ST_BUS) ? load_val(cfg.bct)
				: load_val(cfg.sct);
		else if (timer_q != '0)
			timer_q <= timer_q - TW'(1);
	end

	// Per-conversion samples and pulses for the comparator
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sample     <= '0;
			shunt_done <= 1'b0;
			bus_done   <= 1'b0;
		end
		else
		begin
			shunt_done <= end_shunt;
			bus_done   <= end_bus;
			if (end_shunt)
			begin
				sample.shunt   <= adc.shunt;
				sample.current <= adc.current;
			end
			if (end_bus)
			begin
				sample.bus   <= adc.bus;
				sample.power <= adc.power;
			end
		end
	end

	// Accumulate every sample until the averaging count is met
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			acc_s_q <= '0;
			acc_c_q <= '0;
			acc_b_q <= '0;
			acc_p_q <= '0;
		end
		else if (restart || (state_q == monitor_pkg::ST_WRAP && last_sample))
		begin
			acc_s_q <= '0;
			acc_c_q <= '0;
			acc_b_q <= '0;
			acc_p_q <= '0;
		end
		else
		begin
			if (end_shunt)
			begin
				acc_s_q <= acc_s_q + AW'(adc.shunt);
				acc_c_q <= acc_c_q + AW'(adc.current);
			end
			if (end_bus)
			begin
				acc_b_q <= acc_b_q + AW'(adc.bus);
				acc_p_q <= acc_p_q + AW'(adc.power);
			end
		end
	end

	// Sample counter and output register update
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count_q     <= '0;
			result      <= '0;
			update_done <= 1'b0;
		end
		else
		begin
			update_done <= 1'b0;
			if (restart)
				count_q <= '0;
			else if (state_q == monitor_pkg::ST_WRAP)
			begin
				count_q <= last_sample ? 10'h0 : count_q + 10'h1;
				if (last_sample)
				begin
					update_done <= 1'b1;
					if (cfg.mode[0])
					begin
						result.shunt   <= 16'(acc_s_q >>> shift);
						result.current <= 16'(acc_c_q >>> shift);
					end
					if (cfg.mode[1])
					begin
						result.bus   <= 16'(acc_b_q >> shift);
						result.power <= 16'(acc_p_q >> shift);
					end
				end
			end
		end
	end

	sequence s_shunt_then_bus;
		end_shunt && cfg.mode[1];
	endsequence

	a_shunt_to_bus: assert property (
		@(posedge clk) disable iff (reset)
		s_shunt_then_bus |=> state_q == monitor_pkg::ST_BUS)
		else $error("bus phase did not follow shunt phase");
	a_avg_update: assert property (
		@(posedge clk) disable iff (reset)
		update_done |-> $past(last_sample) && $past(count_q) != 10'h0
		|| $past(shift) == 4'h0)
		else $error("outputs updated before averaging count");
endmodule

// file: hdl/monitor_alert_logic.sv
`include "monitor_consts.svh"
module monitor_alert_logic #(
	parameter int unsigned CONV_CYC [8] = `CONV_CYC_DEFAULT
) (
	input  logic               clk,
	input  logic               reset,
	input  logic [7:0]         reg_addr,
	input  logic [15:0]        reg_wdata,
	input  logic               reg_wr,
	input  logic               reg_rd,
	output logic [15:0]        reg_rdata,
	input  monitor_pkg::meas_t adc,
	output logic [15:0]        calibration,
	input  logic               alert_in,
	output logic               alert_out,
	output logic               alert_oe
);
	logic [15:0]             config_q;
	logic [15:0]             sel_q;
	logic [15:0]             thr_q;
	logic [15:0]             cal_q;
	logic                    aff_q;
	logic                    cdf_q;
	logic                    boot_q;
	logic                    restart_q;
	logic                    pin_meta_q;
	logic                    pin_sync_q;
	logic                    alert_oe_q;
	logic                    alert_oe_d;
	logic [15:0]             rdata_q;
	logic                    cfg_wr;
	logic                    sel_rd;
	logic                    wr_powerdown;
	logic                    shunt_done;
	logic                    bus_done;
	logic                    update_done;
	logic                    cmp_valid;
	logic                    violate;
	logic                    alert_active;
	monitor_pkg::meas_t      sample;
	monitor_pkg::meas_t      result;
	monitor_pkg::alert_sel_t func_sel;

	// Register strobes
	assign cfg_wr = reg_wr && reg_addr == `OFS_CONFIG;
	assign sel_rd = reg_rd && reg_addr == `OFS_ALERT_SEL;
	assign wr_powerdown = reg_wdata[`CFG_MODE_LSB +: 2] == 2'b00;
	assign func_sel = monitor_pkg::alert_sel_t'(
		sel_q[`SEL_FUNC_MSB:`SEL_FUNC_LSB]);
	assign calibration = cal_q;

	// Configuration register; any write restarts conversion
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			config_q <= `CFG_RST;
		else if (cfg_wr)
			config_q <= reg_wdata;
	end

	// Writable control and limit registers
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sel_q <= `SEL_RST;
			thr_q <= `THR_RST;
			cal_q <= `CAL_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `OFS_ALERT_SEL)
				sel_q <= reg_wdata & `SEL_WMASK;
			if (reg_addr == `OFS_THRESHOLD)
				thr_q <= reg_wdata;
			if (reg_addr == `OFS_CALIB)
				cal_q <= reg_wdata;
		end
	end

	// Restart pulse after reset release and each config write
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			boot_q    <= 1'b1;
			restart_q <= 1'b0;
		end
		else
		begin
			boot_q    <= 1'b0;
			restart_q <= cfg_wr || boot_q;
		end
	end

	conv_sequencer #(
		.CONV_CYC (CONV_CYC)
	) u_seq (
		.clk         (clk),
		.reset       (reset),
		.restart     (restart_q),
		.cfg         (monitor_pkg::conv_cfg_t'(
			config_q[`CFG_FIELDS_MSB:`CFG_MODE_LSB])),
		.adc         (adc),
		.sample      (sample),
		.shunt_done  (shunt_done),
		.bus_done    (bus_done),
		.update_done (update_done),
		.result      (result)
	);

	alert_compare u_cmp (
		.sel        (func_sel),
		.limit      (thr_q),
		.sample     (sample),
		.shunt_done (shunt_done),
		.bus_done   (bus_done),
		.cmp_valid  (cmp_valid),
		.violate    (violate)
	);

	// Alert function flag; a new violation beats any clear
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			aff_q <= 1'b0;
		else if (cmp_valid && violate)
			aff_q <= 1'b1;
		else if (sel_q[`SEL_LATCH])
		begin
			if (cfg_wr || sel_rd)
				aff_q <= 1'b0;
		end
		else if (cmp_valid)
			aff_q <= 1'b0;
	end

	// Conversion done flag; completion beats any clear
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			cdf_q <= 1'b0;
		else if (update_done)
			cdf_q <= 1'b1;
		else if ((cfg_wr && !wr_powerdown) || sel_rd)
			cdf_q <= 1'b0;
	end

	// Alert source: limit flag, plus ready when routed
	always_comb
	begin
		alert_active = aff_q
			|| (sel_q[`SEL_READY_EN] && cdf_q);
		alert_oe_d = alert_active ^ sel_q[`SEL_POL];
	end

	// Open-drain driver only ever pulls low
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			alert_oe_q <= 1'b0;
		else
			alert_oe_q <= alert_oe_d;
	end
	assign alert_oe = alert_oe_q;
	assign alert_out = 1'b0;

	// Pin level readback through two flops
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
		end
		else
		begin
			pin_meta_q <= alert_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	function automatic logic [15:0] read_mux(input logic [7:0] addr);
		unique case (addr)
			`OFS_CONFIG:    read_mux = config_q;
			`OFS_SHUNT:     read_mux = result.shunt;
			`OFS_BUS:       read_mux = result.bus;
			`OFS_POWER:     read_mux = result.power;
			`OFS_CURRENT:   read_mux = result.current;
			`OFS_CALIB:     read_mux = cal_q;
			`OFS_ALERT_SEL:
			begin
				read_mux = sel_q;
				read_mux[`SEL_AFF] = aff_q;
				read_mux[`SEL_CDF] = cdf_q;
				read_mux[`SEL_PIN] = pin_sync_q;
			end
			`OFS_THRESHOLD: read_mux = thr_q;
			default:        read_mux = 16'h0000;
		endcase
	endfunction

	// Read data captured on the read strobe
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			rdata_q <= 16'h0000;
		else if (reg_rd)
			rdata_q <= read_mux(reg_addr);
	end
	assign reg_rdata = rdata_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_violation;
		cmp_valid && violate;
	endsequence

	sequence s_held_alert;
		sel_q[`SEL_LATCH] && aff_q && !cfg_wr && !sel_rd;
	endsequence

	a_flag_on_violation: assert property (
		s_violation |=> aff_q ##1 alert_oe_q == !$past(sel_q[`SEL_POL]))
		else $error("violation did not raise flag and alert");
	a_latch_holds: assert property (
		s_held_alert |=> aff_q)
		else $error("latched flag dropped without a clear");
	a_latch_clear: assert property (
		sel_q[`SEL_LATCH] && (cfg_wr || sel_rd) && !cmp_valid
		|=> !aff_q)
		else $error("latched flag not cleared");
	a_unlatched_follow: assert property (
		!sel_q[`SEL_LATCH] && cmp_valid && !violate |=> !aff_q)
		else $error("unlatched flag did not follow compare");
	a_ready_set: assert property (
		update_done |=> cdf_q)
		else $error("ready flag not set on update");
	a_ready_clear: assert property (
		sel_rd && !update_done |=> !cdf_q)
		else $error("ready flag not cleared by read");
	a_ready_powerdown: assert property (
		cfg_wr && wr_powerdown && cdf_q && !sel_rd |=> cdf_q)
		else $error("power-down write cleared ready flag");
	a_alert_polarity: assert property (
		alert_oe == ($past(alert_active) ^ $past(sel_q[`SEL_POL])))
		else $error("alert level does not match polarity");
	a_limit_only: assert property (
		!sel_q[`SEL_READY_EN] && !aff_q && !sel_q[`SEL_POL]
		|=> !alert_oe)
		else $error("alert asserted without a limit violation");
	a_priority: assert property (
		func_sel.shunt_over_limit && shunt_done
		&& sample.shunt > $signed(thr_q) |-> cmp_valid && violate)
		else $error("top priority function not honoured");
	a_under_limit: assert property (
		func_sel == 5'b01000 && shunt_done
		&& sample.shunt < $signed(thr_q) |-> violate)
		else $error("under-limit not detected");
	a_bus_compare: assert property (
		func_sel == 5'b00001 && !bus_done |-> !cmp_valid)
		else $error("power compared outside a bus conversion");
	a_pin_low_only: assert property (
		alert_out == 1'b0)
		else $error("alert pin driven high");
	a_cfg_store: assert property (
		cfg_wr |=> config_q == $past(reg_wdata))
		else $error("configuration write not stored");
	a_thr_store: assert property (
		reg_wr && reg_addr == `OFS_THRESHOLD |=> thr_q == $past(reg_wdata))
		else $error("threshold write not stored");
	a_sel_readonly: assert property (
		(sel_q & ~`SEL_WMASK) == 16'h0000)
		else $error("read-only select bits stored");
	a_restart_on_cfg: assert property (
		cfg_wr |=> restart_q)
		else $error("configuration write did not restart");
	a_ready_route: assert property (
		sel_q[`SEL_READY_EN] && cdf_q && !sel_q[`SEL_POL] |=> alert_oe)
		else $error("ready not routed to alert");
	a_no_function: assert property (
		func_sel == 5'b00000 |-> !cmp_valid)
		else $error("compare without an enabled function");
	a_shunt_timing: assert property (
		(func_sel.shunt_over_limit || func_sel.shunt_under_limit)
		&& cmp_valid |-> shunt_done)
		else $error("shunt compared outside a shunt conversion");
	a_bus_over: assert property (
		func_sel == 5'b00100 && bus_done && sample.bus > thr_q |-> violate)
		else $error("bus over-limit not detected");
	a_power_over: assert property (
		func_sel == 5'b00001 && bus_done && sample.power > thr_q
		|-> cmp_valid && violate)
		else $error("power over-limit not detected");
	a_flag_readback: assert property (
		sel_rd |=> reg_rdata[`SEL_AFF] == $past(aff_q))
		else $error("function flag not read back");
	a_ready_readback: assert property (
		sel_rd |=> reg_rdata[`SEL_CDF] == $past(cdf_q))
		else $error("ready flag not read back");
	a_pin_readback: assert property (
		sel_rd |=> reg_rdata[`SEL_PIN] == $past(pin_sync_q))
		else $error("pin level not read back");
endmodule

// file: hdl/monitor_consts.svh
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH
// Functional notes
// - Conversion time selectable, 140 us to 8.244 ms
// - Shunt time, bus time, averaging set independently
// - One threshold register serves selected function
// - Five alert functions selected by enable bits
// - Highest enabled function bit wins, others ignored
// - Alert output is open-drain, pull or release
// - Ready indication may share the alert output
// - Without ready enable, alert follows limit only
// - Function flag set on every limit violation
// - Polarity bit picks alert active level
// - Latched alert held until config write, flags read
// - Shunt functions compared after each shunt conversion
// - Bus functions compared after each bus conversion
// - Power function compared after each bus conversion
// - Ready flag set when averaged cycle completes
// - Ready cleared by non-powerdown config write, status read
// - Outputs updated only after full averaging count

// Clock and conversion times
`define CLK_PERIOD_NS 10
`define CT0_NS 140000
`define CT1_NS 204000
`define CT2_NS 332000
`define CT3_NS 588000
`define CT4_NS 1100000
`define CT5_NS 2116000
`define CT6_NS 4156000
`define CT7_NS 8244000
`define CT_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC_DEFAULT '{`CT_CYC(`CT0_NS), `CT_CYC(`CT1_NS), \
	`CT_CYC(`CT2_NS), `CT_CYC(`CT3_NS), `CT_CYC(`CT4_NS), \
	`CT_CYC(`CT5_NS), `CT_CYC(`CT6_NS), `CT_CYC(`CT7_NS)}

// Register offsets
`define OFS_CONFIG 8'h00
`define OFS_SHUNT 8'h01
`define OFS_BUS 8'h02
`define OFS_POWER 8'h03
`define OFS_CURRENT 8'h04
`define OFS_CALIB 8'h05
`define OFS_ALERT_SEL 8'h06
`define OFS_THRESHOLD 8'h07

// Reset values
`define CFG_RST 16'h4127
`define SEL_RST 16'h0000
`define THR_RST 16'h0000
`define CAL_RST 16'h0000

// Configuration fields
`define CFG_MODE_LSB 0
`define CFG_FIELDS_MSB 11

// Alert select and flags fields
`define SEL_FUNC_LSB 11
`define SEL_FUNC_MSB 15
`define SEL_READY_EN 10
`define SEL_AFF 4
`define SEL_CDF 3
`define SEL_PIN 2
`define SEL_POL 1
`define SEL_LATCH 0
`define SEL_WMASK 16'hfc03
`endif

// file: hdl/monitor_pkg.sv
package monitor_pkg;
	// One set of measured or averaged values
	typedef struct packed {
		logic signed [15:0] shunt;
		logic [15:0]        bus;
		logic signed [15:0] current;
		logic [15:0]        power;
	} meas_t;

	// Conversion fields of the configuration word
	typedef struct packed {
		logic [2:0] avg;
		logic [2:0] bct;
		logic [2:0] sct;
		logic [2:0] mode;
	} conv_cfg_t;

	// Alert function enables, highest priority first
	typedef struct packed {
		logic shunt_over_limit;
		logic shunt_under_limit;
		logic bus_over_limit;
		logic bus_under_limit;
		logic power_over_limit;
	} alert_sel_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_SHUNT = 4'b0010,
		ST_BUS   = 4'b0100,
		ST_WRAP  = 4'b1000
	} seq_state_t;
endpackage

// file: testbench/front_end_model.sv
module front_end_model (
	input  wire logic               clk,
	input  wire logic signed [15:0] shunt_v,
	input  wire logic [15:0]        bus_v,
	input  wire logic [15:0]        calibration,
	input  wire logic               alert_out,
	input  wire logic               alert_oe,
	output monitor_pkg::meas_t      adc,
	output logic                    alert_in
);
	timeunit 1ns;
	timeprecision 1ps;

	int cur;
	int pwr;

	// Front-end values: current scaled by calibration, power from it
	always_comb
	begin
		cur = int'(shunt_v) * int'(calibration) / 2048;
		pwr = (cur < 0) ? 0 : cur * int'(bus_v) / 20000;
		adc.shunt = shunt_v;
		adc.bus = bus_v;
		adc.current = cur[15:0];
		adc.power = pwr[15:0];
	end

	// Alert wire with pull-up, low only while the device pulls it
	assign alert_in = alert_oe ? alert_out : 1'b1;
endmodule

// file: testbench/monitor_alert_logic_bench.sv
module monitor_alert_logic_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned CYC [8] = '{20, 24, 28, 32, 36, 40, 44, 48};

	typedef struct packed {
		logic [15:0] sel;
		logic [15:0] shunt;
		logic [15:0] bus;
		logic        oe;
	} case_t;

	logic               clk;
	logic               reset;
	logic [7:0]         reg_addr;
	logic [15:0]        reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [15:0]        reg_rdata;
	monitor_pkg::meas_t adc;
	logic [15:0]        calibration;
	logic               alert_in;
	logic               alert_out;
	logic               alert_oe;
	logic signed [15:0] shunt_v;
	logic [15:0]        bus_v;
	logic [15:0]        rd_val;
	case_t              cases [11];
	int                 fails;
	int                 compares;
	int                 cyc;
	int                 t_rise;

	monitor_alert_logic #(.CONV_CYC(CYC)) i_dut (
		.clk         (clk),
		.reset       (reset),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_wr      (reg_wr),
		.reg_rd      (reg_rd),
		.reg_rdata   (reg_rdata),
		.adc         (adc),
		.calibration (calibration),
		.alert_in    (alert_in),
		.alert_out   (alert_out),
		.alert_oe    (alert_oe)
	);

	front_end_model i_front (
		.clk         (clk),
		.shunt_v     (shunt_v),
		.bus_v       (bus_v),
		.calibration (calibration),
		.alert_out   (alert_out),
		.alert_oe    (alert_oe),
		.adc         (adc),
		.alert_in    (alert_in)
	);

	// Clock and cycle count
	initial
	begin
		clk = 1'b0;
		cyc = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe, then one idle cycle
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask

	// One-cycle read strobe, data taken once settled
	task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Bounded wait for the alert enable level
	task automatic wait_oe(input logic lvl);
		int n;
		n = 0;
		while (alert_oe !== lvl && n < 400)
		begin
			@(posedge clk);
			#1 n++;
		end
		check1(alert_oe, lvl);
		if (alert_oe !== lvl)
			complete_run();
	endtask

	// Main sequence
	initial
	begin
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		shunt_v = 16'sd0;
		bus_v = 16'h0000;
		fails = 0;
		compares = 0;
		cases = '{
			'{16'h8000, 16'd200, 16'd50, 1'b1},
			'{16'hc000, 16'd50, 16'd50, 1'b0},
			'{16'h4000, 16'hfffb, 16'd50, 1'b1},
			'{16'h8000, 16'd100, 16'd50, 1'b0},
			'{16'h2000, 16'd50, 16'd300, 1'b1},
			'{16'h2000, 16'd50, 16'd100, 1'b0},
			'{16'h1000, 16'd50, 16'd50, 1'b1},
			'{16'h0800, 16'd16000, 16'd50, 1'b0},
			'{16'h0800, 16'd16000, 16'd9568, 1'b1},
			'{16'h8002, 16'd50, 16'd50, 1'b1},
			'{16'h8002, 16'd200, 16'd50, 1'b0}};
		repeat (16) @(posedge clk);
		#1;
		check16(reg_rdata, 16'h0000);
		check1(alert_oe, 1'b0);
		check1(alert_out, 1'b0);
		reset = 1'b0;
		idle(4);

		// Reset values, read-back and unmapped space
		reg_read(8'h00, rd_val);
		check16(rd_val, 16'h4127);
		reg_read(8'h06, rd_val);
		check16(rd_val & 16'hfc1f, 16'h0004);
		reg_read(8'h07, rd_val);
		check16(rd_val, 16'h0000);
		check16(calibration, 16'h0000);
		reg_read(8'h08, rd_val);
		check16(rd_val, 16'h0000);
		reg_write(8'h07, 16'h0064);
		reg_read(8'h07, rd_val);
		check16(rd_val, 16'h0064);
		reg_write(8'h05, 16'h0a00);
		check16(calibration, 16'h0a00);
		reg_write(8'h06, 16'hffff);
		reg_read(8'h06, rd_val);
		check16(rd_val & 16'hfc03, 16'hfc03);
		reg_write(8'h00, 16'h0e49);
		reg_read(8'h00, rd_val);
		check16(rd_val, 16'h0e49);
		reg_write(8'h00, 16'h0007);

		// Every alert function, priority and polarity, unlatched
		foreach (cases[i])
		begin
			shunt_v = cases[i].shunt;
			bus_v = cases[i].bus;
			reg_write(8'h06, cases[i].sel);
			idle(45);
			wait_oe(cases[i].oe);
			reg_read(8'h06, rd_val);
			check16(rd_val & 16'hfc13, cases[i].sel |
				{11'h000, cases[i].oe ^ cases[i].sel[1], 4'h0});
		end

		// Latched alert held until flags read, then until config write
		shunt_v = 16'sd200;
		reg_write(8'h06, 16'h8001);
		wait_oe(1'b1);
		shunt_v = 16'sd50;
		idle(100);
		check1(alert_oe, 1'b1);
		check1(alert_in, 1'b0);
		reg_read(8'h06, rd_val);
		check16(rd_val & 16'hfc17, 16'h8011);
		wait_oe(1'b0);
		idle(4);
		check1(alert_in, 1'b1);
		shunt_v = 16'sd200;
		wait_oe(1'b1);
		shunt_v = 16'sd50;
		reg_write(8'h00, 16'h0007);
		wait_oe(1'b0);

		// Ready on the alert wire, averaging over four cycles
		shunt_v = 16'sh0123;
		bus_v = 16'h0456;
		reg_write(8'h00, 16'h0207);
		reg_write(8'h06, 16'h0400);
		wait_oe(1'b1);
		t_rise = cyc;
		reg_read(8'h06, rd_val);
		check16(rd_val & 16'hfc1b, 16'h0408);
		wait_oe(1'b0);
		reg_read(8'h01, rd_val);
		check16(rd_val, 16'h0123);
		reg_read(8'h02, rd_val);
		check16(rd_val, 16'h0456);
		reg_read(8'h03, rd_val);
		check16(rd_val, 16'h0014);
		reg_read(8'h04, rd_val);
		check16(rd_val, 16'h016b);
		wait_oe(1'b1);
		check16(16'(cyc - t_rise), 16'd164);

		// Power-down write keeps the ready flag, a read clears it
		reg_write(8'h00, 16'h0200);
		idle(5);
		check1(alert_oe, 1'b1);
		reg_read(8'h06, rd_val);
		wait_oe(1'b0);
		idle(200);
		check1(alert_oe, 1'b0);
		reg_write(8'h00, 16'h0201);
		wait_oe(1'b1);
		complete_run();
	end
endmodule
